// ==== core/stp_param_guard.sv ====
// Spanning-tree parameter guard: holds management-set timers, priorities
// and path cost within their legal ranges, runs the one-second time base,
// hello and hold timers, watches forwarded-frame transit time and drives
// the BPDU encoder. Register port is plain, read data one cycle later.
// Assumes a same-clock octet sink and same-clock forwarding pulses.
`timescale 1ns/100ps
`default_nettype none
`include "stp_defines.svh"
module stp_param_guard #(
    parameter int TICK_CYCLES = `STP_CLK_HZ * `STP_TICK_S,
    parameter logic [15:0] PORT_NUM = 16'h0001,
    parameter logic [2:0] LINK_SPEED = 3'd3
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [47:0] bridge_addr,
    input wire logic fwd_rx,
    input wire logic fwd_tx,
    output logic fwd_discard,
    input wire logic tx_ready,
    output logic tx_valid,
    output stp_pkg::stp_octet_t tx_data,
    output logic tx_last
);
    import stp_pkg::*;

    initial begin
        if (TICK_CYCLES < 2 || PORT_NUM == 16'h0000 || PORT_NUM > 16'h00ff || LINK_SPEED > 3'd5) begin
            $error("stp_param_guard: unsupported parameter value");
        end
    end

    function automatic logic [15:0] speed_cost(input logic [2:0] sel);
        logic [15:0] c;
        c = `STP_COST_100M;
        case (sel)
            3'd0: c = `STP_COST_4M;
            3'd1: c = `STP_COST_10M;
            3'd2: c = `STP_COST_16M;
            3'd3: c = `STP_COST_100M;
            3'd4: c = `STP_COST_1G;
            3'd5: c = `STP_COST_10G;
            default: c = `STP_COST_100M;
        endcase
        return c;
    endfunction

    localparam logic [15:0] COST_RST = speed_cost(LINK_SPEED);
    localparam logic [26:0] TICK_LAST = 27'(TICK_CYCLES - 1);

    // Management-held parameters, status flags and read data.
    logic [7:0] hello_ff, nxt_hello;
    logic [7:0] max_age_ff, nxt_max_age;
    logic [7:0] fwd_ff, nxt_fwd;
    logic [15:0] br_prio_ff, nxt_br_prio;
    logic [7:0] port_prio_ff, nxt_port_prio;
    logic [15:0] cost_ff, nxt_cost;
    logic [7:0] transit_ff, nxt_transit;
    logic root_ff, nxt_root;
    logic tc_ff, nxt_tc;
    logic tca_ff, nxt_tca;
    logic reject_ff, nxt_reject;
    logic discard_seen_ff, nxt_discard_seen;
    logic [31:0] rdata_ff, nxt_rdata;

    // Time base, timers and transmit control.
    logic [26:0] tick_cnt_ff, nxt_tick_cnt;
    logic tick_ff, nxt_tick;
    logic [7:0] hello_cnt_ff, nxt_hello_cnt;
    logic hold_ff, nxt_hold;
    logic pend_cfg_ff, nxt_pend_cfg;
    logic pend_tcn_ff, nxt_pend_tcn;
    logic start_ff, nxt_start;
    logic start_tcn_ff, nxt_start_tcn;
    logic transit_on_ff, nxt_transit_on;
    logic [7:0] transit_cnt_ff, nxt_transit_cnt;
    logic discard_ff, nxt_discard;

    logic enc_busy;
    logic wr_timer, timers_ok;
    logic [7:0] cand_hello, cand_max, cand_fwd;
    logic cfg_req;

    // A timer write is checked as a whole triple against ranges and relations.
    always_comb begin
        cand_hello = hello_ff;
        cand_max = max_age_ff;
        cand_fwd = fwd_ff;
        wr_timer = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                `STP_OFF_HELLO: begin
                    cand_hello = reg_wdata[7:0];
                    wr_timer = 1'b1;
                end
                `STP_OFF_MAX_AGE: begin
                    cand_max = reg_wdata[7:0];
                    wr_timer = 1'b1;
                end
                `STP_OFF_FWD_DELAY: begin
                    cand_fwd = reg_wdata[7:0];
                    wr_timer = 1'b1;
                end
                default: wr_timer = 1'b0;
            endcase
        end
        timers_ok = (reg_wdata[31:8] == 24'h0) && (cand_hello >= `STP_HELLO_MIN)
            && (cand_hello <= `STP_HELLO_MAX) && (cand_max >= `STP_MAX_AGE_MIN)
            && (cand_max <= `STP_MAX_AGE_MAX) && (cand_fwd >= `STP_FWD_MIN)
            && (cand_fwd <= `STP_FWD_MAX)
            && ({cand_fwd, 1'b0} - 9'd2 >= {1'b0, cand_max})
            && ({1'b0, cand_max} >= {cand_hello, 1'b0} + 9'd2);
    end

    // Register writes and reads.
    always_comb begin
        nxt_hello = hello_ff;
        nxt_max_age = max_age_ff;
        nxt_fwd = fwd_ff;
        nxt_br_prio = br_prio_ff;
        nxt_port_prio = port_prio_ff;
        nxt_cost = cost_ff;
        nxt_transit = transit_ff;
        nxt_root = root_ff;
        nxt_tc = tc_ff;
        nxt_tca = tca_ff;
        nxt_reject = reject_ff;
        nxt_discard_seen = discard_seen_ff || discard_ff;
        nxt_rdata = 32'h0;
        if (wr_timer) begin
            if (timers_ok) begin
                nxt_hello = cand_hello;
                nxt_max_age = cand_max;
                nxt_fwd = cand_fwd;
            end else begin
                nxt_reject = 1'b1;
            end
        end
        if (reg_wr) begin
            case (reg_addr)
                `STP_OFF_BR_PRIO: begin
                    if (reg_wdata[31:16] == 16'h0) nxt_br_prio = reg_wdata[15:0];
                    else nxt_reject = 1'b1;
                end
                `STP_OFF_PORT_PRIO: begin
                    if (reg_wdata[31:8] == 24'h0) nxt_port_prio = reg_wdata[7:0];
                    else nxt_reject = 1'b1;
                end
                `STP_OFF_PATH_COST: begin
                    if (reg_wdata[31:16] == 16'h0 && reg_wdata[15:0] >= `STP_COST_MIN) begin
                        nxt_cost = reg_wdata[15:0];
                    end else begin
                        nxt_reject = 1'b1;
                    end
                end
                `STP_OFF_TRANSIT: begin
                    if (reg_wdata[31:0] >= 32'h1 && reg_wdata[31:0] <= 32'(`STP_DELAY_MAX_S)) begin
                        nxt_transit = reg_wdata[7:0];
                    end else begin
                        nxt_reject = 1'b1;
                    end
                end
                `STP_OFF_CTRL: begin
                    nxt_root = reg_wdata[`STP_CTRL_ROOT];
                    nxt_tc = reg_wdata[`STP_CTRL_TC];
                    nxt_tca = reg_wdata[`STP_CTRL_TCA];
                    if (reg_wdata[`STP_CTRL_LOAD_COST]) begin
                        nxt_cost = speed_cost(reg_wdata[`STP_CTRL_SPEED_LO +: 3]);
                    end
                end
                `STP_OFF_STATUS: begin
                    // Write one to clear; a discard in the same cycle still lands.
                    if (reg_wdata[`STP_ST_REJECT]) nxt_reject = 1'b0;
                    if (reg_wdata[`STP_ST_DISCARD]) nxt_discard_seen = discard_ff;
                end
                // Timer offsets land here; their verdict was already set above.
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `STP_OFF_HELLO: nxt_rdata = {24'h0, hello_ff};
                `STP_OFF_MAX_AGE: nxt_rdata = {24'h0, max_age_ff};
                `STP_OFF_FWD_DELAY: nxt_rdata = {24'h0, fwd_ff};
                `STP_OFF_BR_PRIO: nxt_rdata = {16'h0, br_prio_ff};
                `STP_OFF_PORT_PRIO: nxt_rdata = {24'h0, port_prio_ff};
                `STP_OFF_PATH_COST: nxt_rdata = {16'h0, cost_ff};
                `STP_OFF_CTRL: nxt_rdata = {29'h0, tca_ff, tc_ff, root_ff};
                `STP_OFF_STATUS: nxt_rdata = {27'h0, discard_seen_ff, pend_cfg_ff | pend_tcn_ff,
                    enc_busy, hold_ff, reject_ff};
                `STP_OFF_TRANSIT: nxt_rdata = {24'h0, transit_ff};
                `STP_OFF_HOLD: nxt_rdata = {24'h0, `STP_HOLD_S};
                default: nxt_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hello_ff <= `STP_HELLO_DEF;
            max_age_ff <= `STP_MAX_AGE_DEF;
            fwd_ff <= `STP_FWD_DEF;
            br_prio_ff <= `STP_BR_PRIO_DEF;
            port_prio_ff <= `STP_PORT_PRIO_DEF;
            cost_ff <= COST_RST;
            transit_ff <= `STP_DELAY_DEF_S;
            root_ff <= 1'b0;
            tc_ff <= 1'b0;
            tca_ff <= 1'b0;
            reject_ff <= 1'b0;
            discard_seen_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            hello_ff <= nxt_hello;
            max_age_ff <= nxt_max_age;
            fwd_ff <= nxt_fwd;
            br_prio_ff <= nxt_br_prio;
            port_prio_ff <= nxt_port_prio;
            cost_ff <= nxt_cost;
            transit_ff <= nxt_transit;
            root_ff <= nxt_root;
            tc_ff <= nxt_tc;
            tca_ff <= nxt_tca;
            reject_ff <= nxt_reject;
            discard_seen_ff <= nxt_discard_seen;
            rdata_ff <= nxt_rdata;
        end
    end

    assign cfg_req = reg_wr && reg_addr == `STP_OFF_CTRL && reg_wdata[`STP_CTRL_SEND_CFG];

    // Seconds are counted from a free-running tick, so a count of N ticks
    // spans N-1 to N seconds: hellos come early rather than late, and the
    // transit watchdog discards early rather than late.
    always_comb begin
        nxt_tick_cnt = (tick_cnt_ff == TICK_LAST) ? 27'h0 : tick_cnt_ff + 27'h1;
        nxt_tick = (tick_cnt_ff == TICK_LAST);
        nxt_hello_cnt = hello_cnt_ff;
        nxt_hold = hold_ff;
        nxt_pend_cfg = pend_cfg_ff || cfg_req;
        nxt_pend_tcn = pend_tcn_ff || (reg_wr && reg_addr == `STP_OFF_CTRL
            && reg_wdata[`STP_CTRL_SEND_TCN]);
        nxt_start = 1'b0;
        nxt_start_tcn = 1'b0;
        if (!root_ff) begin
            nxt_hello_cnt = 8'h0;
        end else if (tick_ff) begin
            if (hello_cnt_ff + 8'h1 >= hello_ff) begin
                nxt_hello_cnt = 8'h0;
                nxt_pend_cfg = 1'b1;
            end else begin
                nxt_hello_cnt = hello_cnt_ff + 8'h1;
            end
        end
        // Hold lasts until the next tick, i.e. no more than the fixed hold time.
        if (tick_ff) nxt_hold = 1'b0;
        // Requests wait at most one hold period, well inside the send limit.
        if (!enc_busy && !start_ff) begin
            if (pend_tcn_ff) begin
                nxt_start = 1'b1;
                nxt_start_tcn = 1'b1;
                nxt_pend_tcn = 1'b0;
            end else if (pend_cfg_ff && !hold_ff) begin
                nxt_start = 1'b1;
                nxt_pend_cfg = cfg_req;
                nxt_hold = 1'b1;
            end
        end
    end

    // Transit watchdog for one frame in flight at a time.
    always_comb begin
        nxt_transit_on = transit_on_ff;
        nxt_transit_cnt = transit_cnt_ff;
        nxt_discard = 1'b0;
        if (fwd_rx) begin
            nxt_transit_on = 1'b1;
            nxt_transit_cnt = 8'h0;
        end else if (transit_on_ff) begin
            if (fwd_tx) begin
                nxt_transit_on = 1'b0;
            end else if (tick_ff) begin
                if (transit_cnt_ff + 8'h1 >= transit_ff) begin
                    nxt_transit_on = 1'b0;
                    nxt_discard = 1'b1;
                end else begin
                    nxt_transit_cnt = transit_cnt_ff + 8'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_ff <= 27'h0;
            tick_ff <= 1'b0;
            hello_cnt_ff <= 8'h0;
            hold_ff <= 1'b0;
            pend_cfg_ff <= 1'b0;
            pend_tcn_ff <= 1'b0;
            start_ff <= 1'b0;
            start_tcn_ff <= 1'b0;
            transit_on_ff <= 1'b0;
            transit_cnt_ff <= 8'h0;
            discard_ff <= 1'b0;
        end else begin
            tick_cnt_ff <= nxt_tick_cnt;
            tick_ff <= nxt_tick;
            hello_cnt_ff <= nxt_hello_cnt;
            hold_ff <= nxt_hold;
            pend_cfg_ff <= nxt_pend_cfg;
            pend_tcn_ff <= nxt_pend_tcn;
            start_ff <= nxt_start;
            start_tcn_ff <= nxt_start_tcn;
            transit_on_ff <= nxt_transit_on;
            transit_cnt_ff <= nxt_transit_cnt;
            discard_ff <= nxt_discard;
        end
    end

    // As root the bridge sends its own id as root, zero cost and zero age;
    // timers go out in 1/256 s units.
    stp_bpdu_enc u_enc (
        .clk(clk),
        .reset_n(reset_n),
        .start(start_ff),
        .is_tcn(start_tcn_ff),
        .flag_tc(tc_ff),
        .flag_tca(tca_ff),
        .root_id({br_prio_ff, bridge_addr}),
        .root_cost(32'h0),
        .bridge_id({br_prio_ff, bridge_addr}),
        .port_id({port_prio_ff, PORT_NUM[7:0]}),
        .msg_age(16'h0000),
        .max_age({max_age_ff, 8'h00}),
        .hello({hello_ff, 8'h00}),
        .fwd_delay({fwd_ff, 8'h00}),
        .tx_ready(tx_ready),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .tx_last(tx_last),
        .busy(enc_busy)
    );

    assign reg_rdata = rdata_ff;
    assign fwd_discard = discard_ff;
endmodule
`default_nettype wire

// ==== core/stp_defines.svh ====
// Constants for the spanning-tree parameter guard and BPDU encoder.
// Included by the package-using design files; holds definitions only.
`ifndef STP_DEFINES_SVH
`define STP_DEFINES_SVH

// Register offsets on the plain register port (byte addresses).
`define STP_OFF_HELLO 8'h00
`define STP_OFF_MAX_AGE 8'h04
`define STP_OFF_FWD_DELAY 8'h08
`define STP_OFF_BR_PRIO 8'h0c
`define STP_OFF_PORT_PRIO 8'h10
`define STP_OFF_PATH_COST 8'h14
`define STP_OFF_CTRL 8'h18
`define STP_OFF_STATUS 8'h1c
`define STP_OFF_TRANSIT 8'h20
`define STP_OFF_HOLD 8'h24

// Control register fields.
`define STP_CTRL_ROOT 0
`define STP_CTRL_TC 1
`define STP_CTRL_TCA 2
`define STP_CTRL_SEND_CFG 3
`define STP_CTRL_SEND_TCN 4
`define STP_CTRL_LOAD_COST 5
`define STP_CTRL_SPEED_LO 8

// Status register fields.
`define STP_ST_REJECT 0
`define STP_ST_HOLD 1
`define STP_ST_BUSY 2
`define STP_ST_PEND 3
`define STP_ST_DISCARD 4

// Timer values in seconds, ranges and defaults.
`define STP_HELLO_MIN 8'h01
`define STP_HELLO_MAX 8'h0a
`define STP_HELLO_DEF 8'h02
`define STP_MAX_AGE_MIN 8'h06
`define STP_MAX_AGE_MAX 8'h28
`define STP_MAX_AGE_DEF 8'h14
`define STP_FWD_MIN 8'h04
`define STP_FWD_MAX 8'h1e
`define STP_FWD_DEF 8'h0f
`define STP_HOLD_S 8'h01
`define STP_DELAY_MAX_S 8'h04
`define STP_DELAY_DEF_S 8'h01

// Priorities and path costs.
`define STP_BR_PRIO_DEF 16'h8000
`define STP_PORT_PRIO_DEF 8'h80
`define STP_COST_MIN 16'h0001
`define STP_COST_4M 16'h00fa
`define STP_COST_10M 16'h0064
`define STP_COST_16M 16'h003e
`define STP_COST_100M 16'h0013
`define STP_COST_1G 16'h0004
`define STP_COST_10G 16'h0002

// BPDU encoding.
`define STP_PROTO_ID 16'h0000
`define STP_VERSION 8'h00
`define STP_TYPE_CFG 8'h00
`define STP_TYPE_TCN 8'h80
`define STP_CFG_OCTETS 6'd35
`define STP_TCN_OCTETS 6'd4

// Time base.
`define STP_CLK_HZ 125000000
`define STP_TICK_S 1

`endif

// ==== core/stp_pkg.sv ====
// Types shared by the spanning-tree parameter guard and its BPDU encoder.
// Needs no other file.
package stp_pkg;
    typedef logic [7:0] stp_octet_t;
    typedef logic [15:0] stp_timer_t;
    typedef enum logic [1:0] {
        STP_ENC_IDLE = 2'b01,
        STP_ENC_SEND = 2'b10
    } stp_enc_state_t;
endpackage

// ==== core/stp_bpdu_enc.sv ====
// BPDU octet serialiser: builds a configuration or notification BPDU
// and hands it out one octet per accepted beat, octet 1 first.
// Assumes a same-clock sink with valid/ready handshake.
`timescale 1ns/100ps
`default_nettype none
`include "stp_defines.svh"
module stp_bpdu_enc (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic is_tcn,
    input wire logic flag_tc,
    input wire logic flag_tca,
    input wire logic [63:0] root_id,
    input wire logic [31:0] root_cost,
    input wire logic [63:0] bridge_id,
    input wire logic [15:0] port_id,
    input wire stp_pkg::stp_timer_t msg_age,
    input wire stp_pkg::stp_timer_t max_age,
    input wire stp_pkg::stp_timer_t hello,
    input wire stp_pkg::stp_timer_t fwd_delay,
    input wire logic tx_ready,
    output logic tx_valid,
    output stp_pkg::stp_octet_t tx_data,
    output logic tx_last,
    output logic busy
);
    import stp_pkg::*;

    localparam int FRAME_W = 280;

    stp_enc_state_t state_ff, nxt_state;
    logic [FRAME_W-1:0] frame_ff, nxt_frame;
    logic [5:0] left_ff, nxt_left;
    logic last_ff, nxt_last;
    logic [FRAME_W-1:0] cfg_frame;
    stp_octet_t flags;

    // Only the two defined flag bits are ever set; the rest go out as zero.
    assign flags = {flag_tca, 6'h00, flag_tc};
    // Fields are laid out most significant first so the top octet leaves first.
    assign cfg_frame = {`STP_PROTO_ID, `STP_VERSION, `STP_TYPE_CFG, flags, root_id,
        root_cost, bridge_id, port_id, msg_age, max_age, hello, fwd_delay};

    always_comb begin
        nxt_state = state_ff;
        nxt_frame = frame_ff;
        nxt_left = left_ff;
        unique case (state_ff)
            STP_ENC_IDLE: begin
                if (start) begin
                    nxt_state = STP_ENC_SEND;
                    if (is_tcn) begin
                        nxt_frame = {`STP_PROTO_ID, `STP_VERSION, `STP_TYPE_TCN, 248'h0};
                        nxt_left = `STP_TCN_OCTETS;
                    end else begin
                        nxt_frame = cfg_frame;
                        nxt_left = `STP_CFG_OCTETS;
                    end
                end
            end
            STP_ENC_SEND: begin
                if (tx_ready) begin
                    nxt_frame = {frame_ff[FRAME_W-9:0], 8'h00};
                    nxt_left = left_ff - 6'd1;
                    if (left_ff == 6'd1) begin
                        nxt_state = STP_ENC_IDLE;
                    end
                end
            end
        endcase
        // Registered so the last-octet mark leaves straight from a flip-flop.
        nxt_last = (nxt_state == STP_ENC_SEND) && (nxt_left == 6'd1);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= STP_ENC_IDLE;
            frame_ff <= '0;
            left_ff <= 6'd0;
            last_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            frame_ff <= nxt_frame;
            left_ff <= nxt_left;
            last_ff <= nxt_last;
        end
    end

    assign tx_valid = state_ff[1];
    assign tx_data = frame_ff[FRAME_W-1:FRAME_W-8];
    assign tx_last = last_ff;
    assign busy = state_ff[1];
endmodule
`default_nettype wire

// ==== testbench/stp_guard_chk.sv ====
// Port checker for the parameter guard and its octet stream.
// Assumes one clock and the bind at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module stp_guard_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic fwd_discard,
    input wire logic tx_ready,
    input wire logic tx_valid,
    input wire stp_pkg::stp_octet_t tx_data,
    input wire logic tx_last
);
    import stp_pkg::*;
    // Octet index within the frame, counted only on accepted beats.
    logic [5:0] oct_ff;
    logic [5:0] nxt_oct;
    always_comb begin
        nxt_oct = oct_ff;
        if (tx_valid && tx_ready) begin
            nxt_oct = tx_last ? 6'h00 : oct_ff + 6'h01;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oct_ff <= 6'h00;
        end else begin
            oct_ff <= nxt_oct;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    hold_fixed_a: assert property (reg_rd && reg_addr == 8'h24 |=> reg_rdata == 32'h1)
        else $error("hold time not one second");
    octet_held_a: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("octet dropped");
    proto_id_a: assert property (tx_valid && oct_ff < 6'h2 |-> tx_data == 8'h00)
        else $error("protocol id wrong");
    version_a: assert property (tx_valid && oct_ff == 6'h2 |-> tx_data == 8'h00)
        else $error("version wrong");
    bpdu_type_a: assert property (tx_valid && oct_ff == 6'h3 |->
        tx_data == 8'h00 || tx_data == 8'h80) else $error("type wrong");
    flag_spare_a: assert property (tx_valid && oct_ff == 6'h4 |-> tx_data[6:1] == 6'h00)
        else $error("spare flag set");
    frame_len_a: assert property (tx_valid && tx_last |-> oct_ff == 6'h22 ||
        (oct_ff == 6'h3 && tx_data == 8'h80)) else $error("frame length wrong");
    timer_units_a: assert property (tx_valid &&
        oct_ff inside {6'h1b, 6'h1c, 6'h1e, 6'h20, 6'h22} |-> tx_data == 8'h00)
        else $error("timer fraction octet not zero");
    discard_pulse_a: assert property (fwd_discard |=> !fwd_discard)
        else $error("discard longer than one cycle");
endmodule
bind stp_param_guard stp_guard_chk u_chk (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fwd_discard(fwd_discard), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last));
`default_nettype wire

// ==== testbench/stp_octet_sink.sv ====
// Peer model: takes BPDU octets, stalling every other cycle on request.
// Assumes the same clock as the guard.
`timescale 1ns/100ps
`default_nettype none
module stp_octet_sink (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic stall,
    input wire logic tx_valid,
    input wire stp_pkg::stp_octet_t tx_data,
    input wire logic tx_last,
    output logic tx_ready
);
    import stp_pkg::*;
    stp_octet_t got [0:63];
    int n;
    int flen;
    int frames;
    logic tog;
    assign tx_ready = !stall || tog;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            n = 0;
            frames = 0;
            tog <= 1'b0;
        end else begin
            tog <= ~tog;
            if (tx_valid && tx_ready) begin
                got[n] = tx_data;
                n = n + 1;
                if (tx_last) begin
                    flen = n;
                    n = 0;
                    frames = frames + 1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/tb_stp_param_guard.sv ====
// Bench for the parameter guard: register steps, BPDU frames, transit.
// Assumes the checker is bound and the sink model is compiled.
`timescale 1ns/100ps
`default_nettype none
module tb_stp_param_guard;
    import stp_pkg::*;
    logic clk = 1'b0;
    logic reset_n, reg_wr, reg_rd, fwd_rx, fwd_tx, fwd_discard, stall;
    logic tx_ready, tx_valid, tx_last;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [47:0] bridge_addr;
    logic [63:0] bid;
    stp_octet_t tx_data;
    stp_octet_t exp_o [0:34];
    logic [15:0] cost [0:5] = '{16'hfa, 16'h64, 16'h3e, 16'h13, 16'h4, 16'h2};
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    stp_param_guard #(.TICK_CYCLES(20)) u_dut (.clk(clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .bridge_addr(bridge_addr), .fwd_rx(fwd_rx), .fwd_tx(fwd_tx),
        .fwd_discard(fwd_discard), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last));
    stp_octet_sink u_sink (.clk(clk), .reset_n(reset_n), .stall(stall), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
    task automatic print_verdict();
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe, so sample it mid-cycle.
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
            input logic [31:0] m = 32'hffffffff);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(reg_rdata & m, e);
    endtask
    task automatic step(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        wr(a, d);
        rdc(a, e);
    endtask
    task automatic sendchk(input logic [31:0] ctrl, input int len);
        int f0;
        f0 = u_sink.frames;
        wr(8'h18, ctrl);
        for (int i = 0; i < 400 && u_sink.frames == f0; i++) @(posedge clk);
        check(u_sink.flen, len);
        for (int i = 0; i < len; i++) check({24'h0, u_sink.got[i]}, {24'h0, exp_o[i]});
    endtask
    task automatic transit(input logic early, input int e);
        int n;
        n = 0;
        @(posedge clk);
        fwd_rx <= 1'b1;
        @(posedge clk);
        fwd_rx <= 1'b0;
        fwd_tx <= early;
        @(posedge clk);
        fwd_tx <= 1'b0;
        repeat (60) begin
            @(negedge clk);
            n += fwd_discard;
        end
        check(n, e);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        {reset_n, reg_wr, reg_rd, fwd_rx, fwd_tx, stall, reg_addr, reg_wdata} = '0;
        bridge_addr = 48'h0a1b2c3d4e5f;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rdc(8'h00, 32'h2);
        rdc(8'h04, 32'h14);
        rdc(8'h08, 32'hf);
        rdc(8'h0c, 32'h8000);
        rdc(8'h10, 32'h80);
        rdc(8'h14, 32'h13);
        rdc(8'h20, 32'h1);
        step(8'h24, 32'h5, 32'h1);
        step(8'h00, 32'hb, 32'h2);
        step(8'h00, 32'h0, 32'h2);
        rdc(8'h1c, 32'h1, 32'h1);
        wr(8'h1c, 32'h1);
        rdc(8'h1c, 32'h0, 32'h1);
        step(8'h00, 32'h1, 32'h1);
        step(8'h04, 32'h1d, 32'h14);
        step(8'h04, 32'h1c, 32'h1c);
        step(8'h00, 32'ha, 32'ha);
        step(8'h04, 32'h15, 32'h1c);
        step(8'h04, 32'h16, 32'h16);
        step(8'h08, 32'h1e, 32'h1e);
        step(8'h04, 32'h29, 32'h16);
        step(8'h04, 32'h28, 32'h28);
        step(8'h08, 32'h3, 32'h1e);
        step(8'h08, 32'h14, 32'h1e);
        step(8'h0c, 32'hffff, 32'hffff);
        step(8'h0c, 32'h10000, 32'hffff);
        step(8'h10, 32'h100, 32'h80);
        step(8'h10, 32'h0, 32'h0);
        step(8'h14, 32'h0, 32'h13);
        step(8'h14, 32'hffff, 32'hffff);
        step(8'h14, 32'h1, 32'h1);
        step(8'h20, 32'h5, 32'h1);
        step(8'h20, 32'h4, 32'h4);
        step(8'h0c, 32'h1234, 32'h1234);
        step(8'h10, 32'h5a, 32'h5a);
        for (int s = 0; s < 6; s++) begin
            wr(8'h18, {21'h0, s[2:0], 8'h20});
            rdc(8'h14, {16'h0, cost[s]});
        end
        exp_o = '{default: 8'h00};
        bid = {16'h1234, bridge_addr};
        for (int i = 0; i < 8; i++) begin
            exp_o[5 + i] = bid[63 - 8 * i -: 8];
            exp_o[17 + i] = bid[63 - 8 * i -: 8];
        end
        exp_o[4] = 8'h01;
        exp_o[25] = 8'h5a;
        exp_o[26] = 8'h01;
        exp_o[29] = 8'h28;
        exp_o[31] = 8'h0a;
        exp_o[33] = 8'h1e;
        stall <= 1'b1;
        sendchk(32'h0a, 35);
        exp_o[3] = 8'h80;
        sendchk(32'h10, 4);
        wr(8'h20, 32'h1);
        transit(1'b0, 1);
        rdc(8'h1c, 32'h10, 32'h10);
        transit(1'b1, 0);
        print_verdict();
    end
endmodule
`default_nettype wire
